/* File: core/atsl_defs.svh */
// Constants of the arc trip supervision logic
`ifndef ATSL_DEFS_SVH
`define ATSL_DEFS_SVH
// Sizes
`define ATSL_UNITS 16
`define ATSL_ZONES 4
`define ATSL_UPZ 4
`define ATSL_NFLT 20
`define ATSL_SW_W 9
`define ATSL_TMR_W 12
`define ATSL_DIV_W 14
`define ATSL_STK_DEPTH 8
`define ATSL_STK_CW 4
// Time base
`define ATSL_CLK_NS 100
`define ATSL_TICK_NS 1000000
// Limits in 1 ms ticks
`define ATSL_PERSIST_MS 12'hbb8
`define ATSL_FAST_MS 12'h007
`define ATSL_BF_SHORT_MS 12'h064
`define ATSL_BF_LONG_MS 12'h096
// Current checks, full scale 100 counts = rated
`define ATSL_MIN_CUR 8'h05
`define ATSL_UNBAL_MUL 11'h005
// Fault codes
`define ATSL_FC_DAMAGED 8'h0b
`define ATSL_FC_PEER_LONG 8'h0c
`define ATSL_FC_COMM 8'h0d
`define ATSL_FC_LINK 8'h0e
`define ATSL_FC_UNBAL 8'h12
`define ATSL_PH_L1 5'h01
`define ATSL_PH_L2 5'h02
`define ATSL_PH_L3 5'h03
// Register map and fields
`define ATSL_A_CTRL 12'h000
`define ATSL_A_STAT 12'h004
`define ATSL_A_FAULT 12'h008
`define ATSL_A_ACK 12'h00c
`define ATSL_SW_RST 9'h000
`define ATSL_ACK_TRIP 0
`define ATSL_ACK_ERASE 1
`endif

/* File: core/atsl_pkg.sv */
// Types shared by the arc trip supervision logic
`include "atsl_defs.svh"
package atsl_pkg;
    // Front panel switches, bit 0 is switch 1
    typedef struct packed {
        logic l2_phase;
        logic mode;
        logic [2:0] matrix;
        logic bf_long;
        logic speed;
        logic criteria;
        logic latch;
    } atsl_sw_type;
    // One fault memory entry
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] code;
    } atsl_fault_type;
    // Phase current samples
    typedef struct packed {
        logic [7:0] l1;
        logic [7:0] l2;
        logic [7:0] l3;
    } atsl_cur_type;
    // Pin levels that cross into the clock domain
    typedef struct packed {
        logic [`ATSL_UNITS-1:0] units;
        logic peer_light;
        logic peer_ok;
        logic comm_ok;
        logic oc_int;
        logic oc_ext;
    } atsl_pins_type;
endpackage

/* File: core/atsl_persist_timer.sv */
// Persistence timer counting ms ticks while a level holds
`timescale 1ns/10ps
`default_nettype none
`include "atsl_defs.svh"
module atsl_persist_timer (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Time base and watched level
    input wire logic tick,
    input wire logic level,
    input wire logic [`ATSL_TMR_W-1:0] limit,
    // Result
    output logic expired
);
    typedef struct packed {
        logic [`ATSL_TMR_W-1:0] cnt;
        logic hit;
    } atsl_tmr_state_type;
    atsl_tmr_state_type s_reg; // Registered state
    atsl_tmr_state_type s_next; // Next state

    // Count up while high, restart on any drop
    always_comb
    begin
        s_next = s_reg;
        if (!level)
        begin
            s_next = '0; // [RL22]
        end
        else
        begin
            // Saturate so a long hold never wraps
            if (tick && s_reg.cnt != '1)
                s_next.cnt = s_reg.cnt + 1'b1; // [RL22]
            s_next.hit = (s_reg.cnt > limit);
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign expired = s_reg.hit;

    a_timer_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        !level |=> !expired && s_reg.cnt == '0) // [RL22]
        else $error("timer did not restart");
    a_timer_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(expired) |-> $past(level) && $past(s_reg.cnt) > $past(limit))
        else $error("timer expired early");
endmodule
`default_nettype wire

/* File: core/atsl_fault_stack.sv */
// Fault memory, newest entry on top
`timescale 1ns/10ps
`default_nettype none
`include "atsl_defs.svh"
module atsl_fault_stack (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Store and erase
    input wire logic push,
    input wire atsl_pkg::atsl_fault_type push_data,
    input wire logic pop,
    // Newest entry and fill level
    output atsl_pkg::atsl_fault_type top,
    output logic [`ATSL_STK_CW-1:0] count
);
    typedef struct packed {
        atsl_pkg::atsl_fault_type [`ATSL_STK_DEPTH-1:0] mem;
        logic [`ATSL_STK_CW-1:0] cnt;
    } atsl_stk_state_type;
    atsl_stk_state_type s_reg; // Registered state
    atsl_stk_state_type s_next; // Next state
    atsl_stk_state_type mid; // After the erase step

    // Erase first, then store, so a new fault is never lost
    always_comb
    begin
        mid = s_reg;
        if (pop && s_reg.cnt != '0)
        begin
            for (int i = 0; i < `ATSL_STK_DEPTH - 1; i++)
                mid.mem[i] = s_reg.mem[i + 1]; // [RL21]
            mid.mem[`ATSL_STK_DEPTH - 1] = '0;
            mid.cnt = s_reg.cnt - 1'b1;
        end
        s_next = mid;
        if (push)
        begin
            // When full the oldest entry falls off the end
            for (int i = 1; i < `ATSL_STK_DEPTH; i++)
                s_next.mem[i] = mid.mem[i - 1];
            s_next.mem[0] = push_data; // [RL20]
            if (mid.cnt != `ATSL_STK_CW'(`ATSL_STK_DEPTH))
                s_next.cnt = mid.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign top = s_reg.mem[0];
    assign count = s_reg.cnt;

    a_stack_erase: assert property (@(posedge hclk) disable iff (!hresetn)
        pop && !push && count != '0 |=> count == $past(count) - 1'b1) // [RL21]
        else $error("erase did not drop an entry");
endmodule
`default_nettype wire

/* File: core/atsl_arc_trip.sv */
// Arc trip relay control and self-supervision with AHB-Lite registers
//
// Contract
// RL1: Sensor active over 3 s raises code 11
// RL2: Damaged unit's sensors pass no light
// RL3: Damaged fault stored with unit address
// RL4: Peer bus high over 3 s: code 12
// RL5: Communication bus failure raises code 13
// RL6: Peer central unit link failure: code 14
// RL7: Unbalance over 20 percent; quiet below 5
// RL8: L2 channel compared only in phase mode
// RL9: Latch off holds relays until acknowledge
// RL10: Criteria on: light only; off: plus overcurrent
// RL11: Relay 2: backup on own overcurrent
// RL12: Relay 4: backup on external overcurrent
// RL13: Speed on: relays 2, 4 fast 7 ms
// RL14: Backup delay 150 ms on, 100 off
// RL15: Matrix switches route zones to groups
// RL16: Mode switch on selects sub-unit mode
// RL17: Installer allows one master per bus
// RL18: Installer gives units unique addresses
// RL19: Set switches before power is applied
// RL20: Fault drives alarm relay, indicator, memory
// RL21: Each erase drops the newest fault code
// RL22: Persistence counters restart on deassert
`timescale 1ns/10ps
`default_nettype none
`include "atsl_defs.svh"
module atsl_arc_trip #(
    parameter int TICK_CYCLES = `ATSL_TICK_NS / `ATSL_CLK_NS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Field pins, asynchronous
    input wire logic [`ATSL_UNITS-1:0] unit_sensor,
    input wire logic binary_peer_bus_in,
    input wire logic binary_peer_link_ok,
    input wire logic comm_bus_ok,
    input wire logic oc_internal,
    input wire logic oc_external,
    // Current samples on this clock
    input wire atsl_pkg::atsl_cur_type cur,
    // Relays and indicators
    output logic [3:0] trip_relay,
    output logic self_supervision_alarm_relay,
    output logic error_led,
    output logic central_mode,
    output logic [`ATSL_ZONES-1:0] zone_light
);
    ////////////////////////////////////////////////////////////////
    // State of the whole block
    typedef struct packed {
        atsl_pkg::atsl_pins_type s1; // First sync stage
        atsl_pkg::atsl_pins_type s2; // Second sync stage
        atsl_pkg::atsl_sw_type sw; // Panel switches
        logic [`ATSL_DIV_W-1:0] div; // ms divider
        logic tick; // ms enable
        logic [3:0] relay; // Trip relays
        logic [`ATSL_ZONES-1:0] zone; // Zone light
        logic [`ATSL_NFLT-1:0] prev; // Fault levels
        logic [`ATSL_NFLT-1:0] pend; // Faults to store
        logic [4:0] phase; // Unbalanced phase
        logic push; // Store strobe
        atsl_pkg::atsl_fault_type ent; // Entry to store
        logic alarm; // Alarm relay
        logic a_wr; // Write data phase
        logic a_rd; // Read data phase
        logic a_hit; // Upper address clear
        logic [11:0] a_addr; // Latched address
        logic [31:0] rdata; // Read data
    } atsl_top_state_type;

    atsl_top_state_type s_reg; // Registered state
    atsl_top_state_type s_next; // Next state

    ////////////////////////////////////////////////////////////////
    // Helpers
    logic [`ATSL_UNITS-1:0] dmg; // Damaged unit flags
    logic [`ATSL_UNITS-1:0] sens_ok; // Gated sensors
    logic [`ATSL_ZONES-1:0] zone_raw; // Light per zone
    logic [`ATSL_ZONES-1:0] zone_lit; // With peer light
    logic peer_long; // Peer bus stuck
    logic light_any; // Any zone lit
    logic crit; // Trip criterion met
    logic grp_a; // Group A zones lit
    logic grp_b; // Group B zones lit
    logic [3:0] cause; // Relay drive causes
    logic lvl_a; // Second relay A level
    logic lvl_b; // Second relay B level
    logic [`ATSL_TMR_W-1:0] lim2; // Second relay delay
    logic [`ATSL_NFLT-1:0] flt; // Fault levels
    logic ack_trip; // Acknowledge write
    logic erase; // Erase write
    logic ctrl_wr; // Switch write
    logic [7:0] mx13; // Max of L1, L3
    logic [7:0] mn13; // Min of L1, L3
    logic [7:0] mx; // Max compared
    logic [7:0] mn; // Min compared
    logic [7:0] diff; // Spread
    logic unbal; // Unbalance level
    logic [4:0] ph_lo; // Lowest phase
    atsl_pkg::atsl_fault_type stk_top; // Newest fault
    logic [`ATSL_STK_CW-1:0] stk_cnt; // Stored faults

    ////////////////////////////////////////////////////////////////
    // Per unit persistence and gating
    genvar g;
    for (g = 0; g < `ATSL_UNITS; g++)
    begin : g_unit
        // Long activation marks the unit damaged
        atsl_persist_timer u_tmr (
            .hclk(hclk),
            .hresetn(hresetn),
            .tick(s_reg.tick),
            .level(s_reg.s2.units[g]),
            .limit(`ATSL_PERSIST_MS),
            .expired(dmg[g]) // [RL1]
        );
        assign sens_ok[g] = s_reg.s2.units[g] & ~dmg[g]; // [RL2]
    end

    // Units grouped into zones
    for (g = 0; g < `ATSL_ZONES; g++)
    begin : g_zone
        assign zone_raw[g] = |sens_ok[g*`ATSL_UPZ +: `ATSL_UPZ];
    end

    // Peer bus light joins the first zone
    assign zone_lit = zone_raw | `ATSL_ZONES'(s_reg.s2.peer_light);
    assign light_any = |zone_lit;

    // Peer bus held active too long
    atsl_persist_timer u_peer (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(s_reg.tick),
        .level(s_reg.s2.peer_light),
        .limit(`ATSL_PERSIST_MS),
        .expired(peer_long) // [RL4]
    );

    ////////////////////////////////////////////////////////////////
    // Trip decision
    // Light only, or light plus overcurrent from anywhere
    assign crit = s_reg.sw.criteria | s_reg.s2.oc_int
        | s_reg.s2.oc_ext; // [RL10]
    // Zone 1 always feeds group A; switches 5-7 steer zones 2-4
    assign grp_a = zone_lit[0]
        | |(zone_lit[3:1] & s_reg.sw.matrix); // [RL15]
    assign grp_b = |(zone_lit[3:1] & ~s_reg.sw.matrix); // [RL15]
    assign cause[0] = grp_a & crit;
    assign cause[2] = grp_b & crit;

    // Second relays: fast trip or breaker failure backup
    assign lvl_a = s_reg.sw.speed ? cause[0]
        : (s_reg.s2.oc_int & light_any); // [RL11] [RL13]
    assign lvl_b = s_reg.sw.speed ? cause[2]
        : (s_reg.s2.oc_ext & light_any); // [RL12] [RL13]
    assign lim2 = s_reg.sw.speed ? `ATSL_FAST_MS
        : (s_reg.sw.bf_long ? `ATSL_BF_LONG_MS
        : `ATSL_BF_SHORT_MS); // [RL14]

    // Delay for the second relay of group A
    atsl_persist_timer u_bf_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(s_reg.tick),
        .level(lvl_a),
        .limit(lim2),
        .expired(cause[1]) // [RL11]
    );

    // Delay for the second relay of group B
    atsl_persist_timer u_bf_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(s_reg.tick),
        .level(lvl_b),
        .limit(lim2),
        .expired(cause[3]) // [RL12]
    );

    ////////////////////////////////////////////////////////////////
    // Unbalance check between phase channels
    assign mx13 = (cur.l1 > cur.l3) ? cur.l1 : cur.l3;
    assign mn13 = (cur.l1 > cur.l3) ? cur.l3 : cur.l1;
    // L2 joins only when it measures phase current
    assign mx = (s_reg.sw.l2_phase && cur.l2 > mx13)
        ? cur.l2 : mx13; // [RL8]
    assign mn = (s_reg.sw.l2_phase && cur.l2 < mn13)
        ? cur.l2 : mn13; // [RL8]
    assign ph_lo = (s_reg.sw.l2_phase && cur.l2 < mn13)
        ? `ATSL_PH_L2
        : ((cur.l1 > cur.l3) ? `ATSL_PH_L3 : `ATSL_PH_L1);
    assign diff = mx - mn;
    // Spread above a fifth of the largest; small currents ignored
    assign unbal = (mx >= `ATSL_MIN_CUR)
        && (11'(diff) * `ATSL_UNBAL_MUL > 11'(mx)); // [RL7]

    // Fault levels in store priority order, lowest first
    assign flt = {unbal, ~s_reg.s2.peer_ok, ~s_reg.s2.comm_ok,
        peer_long, dmg}; // [RL5] [RL6]

    ////////////////////////////////////////////////////////////////
    // Register writes in the data phase
    assign ctrl_wr = s_reg.a_wr && s_reg.a_hit
        && s_reg.a_addr == `ATSL_A_CTRL;
    assign ack_trip = s_reg.a_wr && s_reg.a_hit
        && s_reg.a_addr == `ATSL_A_ACK && hwdata[`ATSL_ACK_TRIP];
    assign erase = s_reg.a_wr && s_reg.a_hit
        && s_reg.a_addr == `ATSL_A_ACK && hwdata[`ATSL_ACK_ERASE];

    // Fault memory
    atsl_fault_stack u_stack (
        .hclk(hclk),
        .hresetn(hresetn),
        .push(s_reg.push),
        .push_data(s_reg.ent),
        .pop(erase), // [RL21]
        .top(stk_top),
        .count(stk_cnt)
    );

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic [4:0] sel; // Fault chosen to store
        logic [`ATSL_NFLT-1:0] rise; // New fault edges
        sel = '0;
        rise = flt & ~s_reg.prev;
        s_next = s_reg;
        // Pins through two stages
        s_next.s1 = {unit_sensor, binary_peer_bus_in,
            binary_peer_link_ok, comm_bus_ok, oc_internal,
            oc_external};
        s_next.s2 = s_reg.s1;
        // One ms enable from the divider
        s_next.tick = 1'b0;
        if (s_reg.div == `ATSL_DIV_W'(TICK_CYCLES - 1))
        begin
            s_next.div = '0;
            s_next.tick = 1'b1;
        end
        else
        begin
            s_next.div = s_reg.div + 1'b1;
        end
        // Relays; with latch off a trip holds until acknowledged
        for (int i = 0; i < 4; i++)
            s_next.relay[i] = cause[i] | (s_reg.relay[i]
                & ~s_reg.sw.latch & ~ack_trip); // [RL9]
        s_next.zone = zone_lit;
        // Capture the phase at the moment unbalance appears
        if (rise[`ATSL_NFLT-1])
            s_next.phase = ph_lo;
        // Lowest pending fault goes first
        for (int i = `ATSL_NFLT - 1; i >= 0; i--)
            if (s_reg.pend[i])
                sel = 5'(i);
        s_next.push = |s_reg.pend;
        s_next.pend = s_reg.pend;
        if (|s_reg.pend)
            s_next.pend[sel] = 1'b0;
        // A new edge wins over the clear of the same bit
        s_next.pend = s_next.pend | rise;
        s_next.prev = flt;
        // Entry built from the chosen fault
        if (sel < 5'(`ATSL_UNITS))
            s_next.ent = '{addr: sel, code: `ATSL_FC_DAMAGED}; // [RL3]
        else if (sel == 5'(`ATSL_UNITS))
            s_next.ent = '{addr: 5'h00, code: `ATSL_FC_PEER_LONG};
        else if (sel == 5'(`ATSL_UNITS + 1))
            s_next.ent = '{addr: 5'h00, code: `ATSL_FC_COMM};
        else if (sel == 5'(`ATSL_UNITS + 2))
            s_next.ent = '{addr: 5'h00, code: `ATSL_FC_LINK};
        else
            s_next.ent = '{addr: s_reg.phase, code: `ATSL_FC_UNBAL};
        // Alarm stands while any code is stored
        s_next.alarm = (stk_cnt != '0); // [RL20]
        // Switch register write
        if (ctrl_wr)
            s_next.sw = hwdata[`ATSL_SW_W-1:0];
        // Address phase capture
        s_next.a_wr = hsel && hready && htrans[1] && hwrite;
        s_next.a_rd = hsel && hready && htrans[1] && !hwrite;
        s_next.a_addr = haddr[11:0];
        s_next.a_hit = (haddr[31:12] == 20'h0_0000);
        // Read data prepared for the data phase
        s_next.rdata = '0;
        if (!s_next.a_rd || !s_next.a_hit)
            s_next.rdata = '0;
        else if (haddr[11:0] == `ATSL_A_CTRL)
            s_next.rdata = 32'(s_next.sw);
        else if (haddr[11:0] == `ATSL_A_STAT)
            s_next.rdata = 32'({~s_reg.sw.mode, s_reg.alarm,
                s_reg.relay, flt});
        else if (haddr[11:0] == `ATSL_A_FAULT)
            s_next.rdata = 32'({stk_cnt, stk_top});
        else
            s_next.rdata = '0;
    end

    ////////////////////////////////////////////////////////////////
    // State register; link health starts good
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_reg <= '0;
            s_reg.s1.peer_ok <= 1'b1;
            s_reg.s1.comm_ok <= 1'b1;
            s_reg.s2.peer_ok <= 1'b1;
            s_reg.s2.comm_ok <= 1'b1;
            s_reg.prev <= '0;
            s_reg.sw <= `ATSL_SW_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_reg.rdata;
    assign trip_relay = s_reg.relay;
    assign self_supervision_alarm_relay = s_reg.alarm; // [RL20]
    assign error_led = s_reg.alarm; // [RL20]
    assign central_mode = ~s_reg.sw.mode; // [RL16]
    assign zone_light = s_reg.zone;

    ////////////////////////////////////////////////////////////////
    // Checks
    a_damaged_gate: assert property (@(posedge hclk) // [RL2]
        disable iff (!hresetn)
        (s_reg.s2.units & ~dmg) == '0 && !s_reg.s2.peer_light
        |=> zone_light == '0)
        else $error("damaged unit light passed");
    a_latch_hold: assert property (@(posedge hclk) // [RL9]
        disable iff (!hresetn)
        !s_reg.sw.latch && trip_relay[0] && !ack_trip
        |=> trip_relay[0])
        else $error("latched relay dropped");
    a_relay_follow: assert property (@(posedge hclk) // [RL9]
        disable iff (!hresetn)
        s_reg.sw.latch && !cause[0] |=> !trip_relay[0])
        else $error("relay did not follow");
    a_criteria_both: assert property (@(posedge hclk) // [RL10]
        disable iff (!hresetn)
        !s_reg.sw.criteria && !s_reg.s2.oc_int
        && !s_reg.s2.oc_ext |-> !cause[0] && !cause[2])
        else $error("trip without overcurrent");
    a_fault_store: assert property (@(posedge hclk) // [RL3]
        disable iff (!hresetn)
        $rose(dmg[5]) && $stable(dmg[4:0]) && s_reg.pend == '0
        |-> ##2 s_reg.push && s_reg.ent.addr == 5'h05
        && s_reg.ent.code == `ATSL_FC_DAMAGED)
        else $error("damaged unit not stored");
    a_alarm_raise: assert property (@(posedge hclk) // [RL20]
        disable iff (!hresetn)
        s_reg.push |-> ##2 self_supervision_alarm_relay)
        else $error("alarm relay not raised");
    a_unbal_quiet: assert property (@(posedge hclk) // [RL7]
        disable iff (!hresetn)
        mx < `ATSL_MIN_CUR |-> !unbal)
        else $error("unbalance below minimum current");
endmodule
`default_nettype wire

/* File: verification/atsl_field_model.sv */
// Field side model: I/O units and peer central unit driving pin levels
`timescale 1ns/10ps
`default_nettype none
module atsl_field_model (
    // Bench commands: unit lights; peer, oc_int, oc_ext, link bad, comm bad
    input wire logic [15:0] light_cmd,
    input wire logic [4:0] flag_cmd,
    // Pin levels toward the block
    output logic [15:0] unit_sensor,
    output logic binary_peer_bus_in,
    output logic binary_peer_link_ok,
    output logic comm_bus_ok,
    output logic oc_internal,
    output logic oc_external
);
    // One sensor line per unit, each unit on its own address
    assign unit_sensor = light_cmd;
    // Peer light and overcurrent information
    assign binary_peer_bus_in = flag_cmd[4];
    assign oc_internal = flag_cmd[3];
    assign oc_external = flag_cmd[2];
    // Links good unless the bench breaks them on purpose
    assign binary_peer_link_ok = ~flag_cmd[1];
    assign comm_bus_ok = ~flag_cmd[0];
endmodule
`default_nettype wire

/* File: verification/atsl_arc_trip_tb.sv */
// Self-checking testbench of the arc trip supervision logic
`timescale 1ns/10ps
`default_nettype none
`include "atsl_defs.svh"
module atsl_arc_trip_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp;
    logic [31:0] hrdata, q;
    logic [15:0] light = 16'h0000;
    logic [4:0] flags = 5'h00;
    atsl_pkg::atsl_cur_type cur = 24'h00_0000;
    logic [15:0] sens;
    logic peer, link_ok, comm_ok, oci, oce, alarm, led, cmode;
    logic [3:0] trip, zl;
    int fail_count = 0, checks_done = 0;
    // Rows: oc_int at 31, ctrl at 28:20, unit lights, expected relays
    logic [31:0] rows [8] = '{32'h0030_0011, 32'h0030_0104, 32'h0130_0101,
        32'h0230_1001, 32'h0030_1004, 32'h0431_0001, 32'h0010_0010,
        32'h8010_0011};
    // Bench clock, 100 ns period
    always #50 hclk = ~hclk;
    atsl_arc_trip #(.TICK_CYCLES(10)) atsl_arc_trip_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .unit_sensor(sens), .binary_peer_bus_in(peer),
        .binary_peer_link_ok(link_ok), .comm_bus_ok(comm_ok),
        .oc_internal(oci), .oc_external(oce), .cur(cur), .trip_relay(trip),
        .self_supervision_alarm_relay(alarm), .error_led(led),
        .central_mode(cmode), .zone_light(zl));
    atsl_field_model atsl_field_model_inst (.light_cmd(light),
        .flag_cmd(flags), .unit_sensor(sens), .binary_peer_bus_in(peer),
        .binary_peer_link_ok(link_ok), .comm_bus_ok(comm_ok),
        .oc_internal(oci), .oc_external(oce));
    ////////////////////////////////////////////////////////////////////////
    // One transfer; hready sampled before anything is released
    task automatic bus(input logic w, input logic [31:0] a, d);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // Compare and count
    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // Counts and verdict
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog, well past the expected 4.9 ms of traffic
    initial
    begin
        #8_000_000;
        fail_count++;
        report_and_stop();
    end
    // Main sequence; switches only set while lights and flags are quiet
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("reset relays", {alarm, cmode, trip}, 6'b01_0000);
        bus(1'b0, 32'h0000_0010, 32'h0);
        chk("unmapped", {hresp, q[30:0]}, 32'h0);
        $display("reset test done");
        // Persistence: peer bus held, unit 5 with a short drop
        bus(1'b1, `ATSL_A_CTRL, 32'h3);
        light <= 16'h0020;
        flags <= 5'h10;
        repeat (15000) @(posedge hclk);
        light <= 16'h0000;
        repeat (5) @(posedge hclk);
        light <= 16'h0020;
        repeat (14895) @(posedge hclk);
        chk("early alarm", alarm, 1'b0);
        repeat (400) @(posedge hclk);
        bus(1'b0, `ATSL_A_FAULT, 32'h0);
        chk("peer", {q[16:13], q[7:0]}, {4'h1, `ATSL_FC_PEER_LONG});
        chk("unit 5 lit", zl[1], 1'b1);
        repeat (15000) @(posedge hclk);
        bus(1'b0, `ATSL_A_FAULT, 32'h0);
        chk("damaged", q[16:0], {4'h2, 5'h05, `ATSL_FC_DAMAGED});
        chk("gated", {alarm, led, zl}, 6'b11_0001);
        flags <= 5'h00;
        bus(1'b1, `ATSL_A_ACK, 32'h2);
        bus(1'b0, `ATSL_A_FAULT, 32'h0);
        chk("erase", {q[16:13], q[7:0]}, {4'h1, `ATSL_FC_PEER_LONG});
        light <= 16'h0000;
        bus(1'b1, `ATSL_A_ACK, 32'h2);
        repeat (5) @(posedge hclk);
        chk("alarm off", {alarm, led}, 2'b00);
        $display("persistence test done");
        // Routing and criteria table
        foreach (rows[i])
        begin
            bus(1'b1, `ATSL_A_CTRL, {23'h0, rows[i][28:20]});
            light <= rows[i][19:4];
            flags <= {1'b0, rows[i][31], 3'b000};
            repeat (30) @(posedge hclk);
            chk("row relays", trip, rows[i][3:0]);
            light <= 16'h0000;
            flags <= 5'h00;
            repeat (30) @(posedge hclk);
            chk("row follow", trip, 4'h0);
        end
        $display("table test done");
        // Breaker-failure backup, short then long delay
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, `ATSL_A_CTRL, k ? 32'hb : 32'h3);
            light <= 16'h0001;
            flags <= 5'h0c;
            repeat (k ? 1450 : 950) @(posedge hclk);
            chk("bf early", trip, 4'b0001);
            repeat (100) @(posedge hclk);
            chk("bf late", trip, 4'b1011);
            light <= 16'h0000;
            flags <= 5'h00;
            repeat (30) @(posedge hclk);
        end
        // Fast second relay
        bus(1'b1, `ATSL_A_CTRL, 32'h7);
        light <= 16'h0001;
        repeat (50) @(posedge hclk);
        chk("fast early", trip, 4'b0001);
        repeat (40) @(posedge hclk);
        chk("fast late", trip, 4'b0011);
        light <= 16'h0000;
        repeat (5) @(posedge hclk);
        // Latch held until acknowledge
        bus(1'b1, `ATSL_A_CTRL, 32'h2);
        light <= 16'h0001;
        repeat (20) @(posedge hclk);
        light <= 16'h0000;
        repeat (20) @(posedge hclk);
        chk("held", trip, 4'b0001);
        bus(1'b1, `ATSL_A_ACK, 32'h1);
        repeat (5) @(posedge hclk);
        chk("acked", trip, 4'h0);
        // Sub-unit mode; central mode output goes low
        bus(1'b1, `ATSL_A_CTRL, 32'h80);
        repeat (3) @(posedge hclk);
        chk("sub-unit", cmode, 1'b0);
        $display("relay test done");
        // Communication and peer link faults
        for (int k = 0; k < 2; k++)
        begin
            flags <= k ? 5'h02 : 5'h01;
            repeat (20) @(posedge hclk);
            bus(1'b0, `ATSL_A_FAULT, 32'h0);
            chk("link", {alarm, q[7:0]}, 9'h10d + k);
            flags <= 5'h00;
            bus(1'b1, `ATSL_A_ACK, 32'h2);
            repeat (5) @(posedge hclk);
            chk("link erased", alarm, 1'b0);
        end
        // Unbalance: low current quiet, L2 only in phase mode
        bus(1'b1, `ATSL_A_CTRL, 32'h100);
        cur <= 24'h04_00_01;
        repeat (20) @(posedge hclk);
        chk("low current", alarm, 1'b0);
        bus(1'b1, `ATSL_A_CTRL, 32'h0);
        cur <= 24'h64_32_64;
        repeat (20) @(posedge hclk);
        chk("l2 ignored", alarm, 1'b0);
        bus(1'b1, `ATSL_A_CTRL, 32'h100);
        repeat (20) @(posedge hclk);
        bus(1'b0, `ATSL_A_FAULT, 32'h0);
        chk("unbal", q[12:0], {`ATSL_PH_L2, `ATSL_FC_UNBAL});
        $display("supervision test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
